// *** core/sbbe_consts.vh ***
/*
 * Constants for the call, bit-test and bounds-check executor: opcode
 * patterns, addressing-mode codes, operand sizes, flag positions and
 * fixed step sizes. Assumes inclusion by bare name from core/ files.
 */
`ifndef SBBE_CONSTS_VH
`define SBBE_CONSTS_VH

// ==========================================================
// Opcode patterns
`define SBBE_CALL_OP        8'h61
`define SBBE_DISP_WORD      8'h00
`define SBBE_DISP_LONG      8'hFF
`define SBBE_BT_STATIC_OP   10'h020
`define SBBE_BT_DYN_TOP     4'h0
`define SBBE_BT_DYN_MID     3'h4
`define SBBE_CHK_TOP        4'h4
`define SBBE_CHK_BIT6       1'h0
`define SBBE_CHK_SZ_WORD    2'h3
`define SBBE_CHK_SZ_LONG    2'h2

// ==========================================================
// Effective address mode and register codes
`define SBBE_MODE_DREG      3'h0
`define SBBE_MODE_AREG      3'h1
`define SBBE_MODE_EXT       3'h7
`define SBBE_REG_LAST_MEM   3'h3
`define SBBE_REG_IMM        3'h4

// ==========================================================
// Operand sizes requested from the operand unit
`define SBBE_SIZE_BYTE      2'h0
`define SBBE_SIZE_WORD      2'h1
`define SBBE_SIZE_LONG      2'h2

// ==========================================================
// Condition code bit positions
`define SBBE_CC_X           4
`define SBBE_CC_N           3
`define SBBE_CC_Z           2
`define SBBE_CC_V           1
`define SBBE_CC_C           0

// ==========================================================
// Steps, stack and trap
`define SBBE_PC_STEP        32'h00000002
`define SBBE_SP_STEP        32'h00000004
`define SBBE_CHK_VECTOR     8'h06

`endif

// *** core/sbbe_exec.v ***
/*
 * Executor for three instructions: the relative subroutine call, the
 * single bit test and the zero-to-bound register check.
 * Assumes: opcode and extension words come from program memory over a
 * req/ack word port; the core's register file answers a data register
 * read in the same cycle; the core's effective-address unit delivers a
 * memory or immediate operand over a req/ack port; stack stores go
 * through a req/ack port. All inputs are synchronous to clk.
 */
`timescale 1ns/1ns
`default_nettype none

`include "sbbe_consts.vh"

// How it works
// - Call drops stack by four, stores return.
// - Call base is opcode address plus two.
// - Zero short displacement fetches word displacement.
// - All-ones short displacement fetches long displacement.
// - Signed displacement added to base; flags kept.
// - Call opcode top byte is 0110 0001.
// - Bit test sets zero flag from inverted bit.
// - Register destination: long, bit number modulo 32.
// - Memory destination: byte access, modulo 8.
// - Bit number zero is least significant bit.
// - Bit number from extension word or register.
// - Static form top ten bits 0000100000.
// - Dynamic form 0000, register, 100, address.
// - Only data modes; dynamic also allows immediate.
// - Only register direct is long; else byte.
// - Negative or above bound traps vector six.
// - Bound and register compared as signed.
// - Negative flag set below zero, cleared above.
// - Check sizes: 11 word, 10 long.
// - Check opcode 0100, register, size, 0, address.

module sbbe_exec (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // Instruction start
    input  wire        start,
    input  wire [31:0] start_pc,
    output wire        busy,
    // Program memory word fetch
    output wire        fetch_req,
    output wire [31:0] fetch_addr,
    input  wire        fetch_ack,
    input  wire [15:0] fetch_data,
    // Data register read
    output wire [2:0]  dreg_sel,
    input  wire [31:0] dreg_data,
    // Effective-address operand read
    output wire        opnd_req,
    output wire [2:0]  opnd_mode,
    output wire [2:0]  opnd_reg,
    output wire [1:0]  opnd_size,
    input  wire        opnd_ack,
    input  wire [31:0] opnd_data,
    // Stack pointer and stack store
    input  wire [31:0] sp_in,
    output wire        push_req,
    output wire [31:0] push_addr,
    output wire [31:0] push_data,
    input  wire        push_ack,
    output wire        sp_we,
    output wire [31:0] sp_out,
    // Program counter and condition codes
    output wire        pc_load,
    output wire [31:0] new_pc,
    input  wire [4:0]  ccr_in,
    output wire        ccr_we,
    output wire [4:0]  ccr_out,
    // Completion and exceptions
    output wire        done,
    output wire        trap,
    output wire [7:0]  trap_vector,
    output wire        illegal,
    output wire        not_mine
);

    // ======================================================
    // States
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_OPC  = 3'h1;
    localparam [2:0] S_DEC  = 3'h2;
    localparam [2:0] S_EXT  = 3'h3;
    localparam [2:0] S_OPND = 3'h4;
    localparam [2:0] S_PUSH = 3'h5;

    localparam [1:0] K_CALL = 2'h0;
    localparam [1:0] K_BT   = 2'h1;
    localparam [1:0] K_CHK  = 2'h2;

    // ======================================================
    // Registers
    reg [2:0]  state_ff;
    reg [31:0] fa_ff;
    reg [31:0] base_ff;
    reg [15:0] op_ff;
    reg [31:0] ext_ff;
    reg [1:0]  ext_left_ff;
    reg [1:0]  kind_ff;
    reg [7:0]  bitn_ff;
    reg [31:0] val_ff;
    reg [31:0] push_addr_ff;
    reg [31:0] push_data_ff;
    reg [31:0] new_pc_ff;
    reg [31:0] sp_out_ff;
    reg [4:0]  ccr_out_ff;
    reg        done_ff;
    reg        pc_load_ff;
    reg        sp_we_ff;
    reg        ccr_we_ff;
    reg        trap_ff;
    reg        illegal_ff;
    reg        not_mine_ff;

    // ======================================================
    // Opcode decode
    wire [2:0] ea_mode = op_ff[5:3];
    wire [2:0] ea_reg  = op_ff[2:0];

    wire is_call = (op_ff[15:8] == `SBBE_CALL_OP);
    wire is_bt_s = (op_ff[15:6] == `SBBE_BT_STATIC_OP);
    wire is_bt_d = (op_ff[15:12] == `SBBE_BT_DYN_TOP)
                && (op_ff[8:6] == `SBBE_BT_DYN_MID);
    wire is_chk  = (op_ff[15:12] == `SBBE_CHK_TOP)
                && (op_ff[6] == `SBBE_CHK_BIT6)
                && ((op_ff[8:7] == `SBBE_CHK_SZ_WORD)
                 || (op_ff[8:7] == `SBBE_CHK_SZ_LONG));

    // Data addressing modes, optionally with immediate
    function ea_ok;
        input [2:0] m;
        input [2:0] r;
        input       imm;
        begin
            if (m == `SBBE_MODE_AREG) begin
                ea_ok = 1'b0;
            end else if (m == `SBBE_MODE_EXT) begin
                ea_ok = (r <= `SBBE_REG_LAST_MEM)
                     || (imm && (r == `SBBE_REG_IMM));
            end else begin
                ea_ok = 1'b1;
            end
        end
    endfunction

    wire ea_bad_bt  = !ea_ok(ea_mode, ea_reg, is_bt_d);
    wire ea_bad_chk = !ea_ok(ea_mode, ea_reg, 1'b0);
    wire ea_is_dreg = (ea_mode == `SBBE_MODE_DREG);
    wire chk_word   = (op_ff[8:7] == `SBBE_CHK_SZ_WORD);

    // ======================================================
    // Operand and bit selection
    wire [31:0] opval  = ea_is_dreg ? dreg_data : opnd_data;
    wire        opnd_ok = ea_is_dreg || opnd_ack;
    wire [4:0]  bit_idx = ea_is_dreg ? bitn_ff[4:0]
                                     : {2'b00, bitn_ff[2:0]};
    wire        bit_val = opval[bit_idx];

    // Signed operands for the bounds check
    wire [31:0] chk_v = chk_word ? {{16{val_ff[15]}}, val_ff[15:0]} : val_ff;
    wire [31:0] chk_b = chk_word ? {{16{opval[15]}}, opval[15:0]} : opval;
    wire        chk_neg  = chk_v[31];
    wire        chk_over = $signed(chk_v) > $signed(chk_b);

    // Call displacement in the selected width
    wire [31:0] disp = (op_ff[7:0] == `SBBE_DISP_WORD)
                     ? {{16{ext_ff[15]}}, ext_ff[15:0]}
                     : (op_ff[7:0] == `SBBE_DISP_LONG) ? ext_ff
                     : {{24{op_ff[7]}}, op_ff[7:0]};

    // ======================================================
    // Handshake outputs
    assign busy       = (state_ff != S_IDLE);
    assign fetch_req  = (state_ff == S_OPC) || (state_ff == S_EXT);
    assign fetch_addr = fa_ff;
    assign dreg_sel   = (state_ff == S_DEC) ? op_ff[11:9] : ea_reg;
    assign opnd_req   = (state_ff == S_OPND) && !ea_is_dreg;
    assign opnd_mode  = ea_mode;
    assign opnd_reg   = ea_reg;
    assign opnd_size  = (kind_ff == K_BT) ? `SBBE_SIZE_BYTE
                      : chk_word ? `SBBE_SIZE_WORD : `SBBE_SIZE_LONG;
    assign push_req   = (state_ff == S_PUSH);
    assign push_addr  = push_addr_ff;
    assign push_data  = push_data_ff;

    // Flopped result outputs; trap vector is a constant
    assign sp_we       = sp_we_ff;
    assign sp_out      = sp_out_ff;
    assign pc_load     = pc_load_ff;
    assign new_pc      = new_pc_ff;
    assign ccr_we      = ccr_we_ff;
    assign ccr_out     = ccr_out_ff;
    assign done        = done_ff;
    assign trap        = trap_ff;
    assign trap_vector = `SBBE_CHK_VECTOR;
    assign illegal     = illegal_ff;
    assign not_mine    = not_mine_ff;

    // ======================================================
    // Sequencer
    always @(posedge clk) begin
        done_ff     <= 1'b0;
        pc_load_ff  <= 1'b0;
        sp_we_ff    <= 1'b0;
        ccr_we_ff   <= 1'b0;
        trap_ff     <= 1'b0;
        illegal_ff  <= 1'b0;
        not_mine_ff <= 1'b0;
        if (rst) begin
            state_ff     <= S_IDLE;
            fa_ff        <= 32'h00000000;
            base_ff      <= 32'h00000000;
            op_ff        <= 16'h0000;
            ext_ff       <= 32'h00000000;
            ext_left_ff  <= 2'h0;
            kind_ff      <= K_CALL;
            bitn_ff      <= 8'h00;
            val_ff       <= 32'h00000000;
            push_addr_ff <= 32'h00000000;
            push_data_ff <= 32'h00000000;
            new_pc_ff    <= 32'h00000000;
            sp_out_ff    <= 32'h00000000;
            ccr_out_ff   <= 5'h00;
        end else begin
            case (state_ff)
                S_IDLE: begin
                    if (start) begin
                        fa_ff    <= start_pc;
                        state_ff <= S_OPC;
                    end
                end
                // Opcode word; base is its address plus two
                S_OPC: begin
                    if (fetch_ack) begin
                        op_ff    <= fetch_data;
                        ext_ff   <= 32'h00000000;
                        base_ff  <= fa_ff + `SBBE_PC_STEP;
                        fa_ff    <= fa_ff + `SBBE_PC_STEP;
                        state_ff <= S_DEC;
                    end
                end
                // Classify, check modes, capture register operands
                S_DEC: begin
                    bitn_ff <= dreg_data[7:0];
                    val_ff  <= dreg_data;
                    if (is_call) begin
                        kind_ff <= K_CALL;
                        if (op_ff[7:0] == `SBBE_DISP_WORD) begin
                            ext_left_ff <= 2'h1;
                            state_ff    <= S_EXT;
                        end else if (op_ff[7:0] == `SBBE_DISP_LONG) begin
                            ext_left_ff <= 2'h2;
                            state_ff    <= S_EXT;
                        end else begin
                            state_ff <= S_PUSH;
                        end
                    end else if (is_bt_s || is_bt_d) begin
                        kind_ff <= K_BT;
                        if (ea_bad_bt) begin
                            illegal_ff <= 1'b1;
                            state_ff   <= S_IDLE;
                        end else if (is_bt_s) begin
                            ext_left_ff <= 2'h1;
                            state_ff    <= S_EXT;
                        end else begin
                            state_ff <= S_OPND;
                        end
                    end else if (is_chk) begin
                        kind_ff <= K_CHK;
                        if (ea_bad_chk) begin
                            illegal_ff <= 1'b1;
                            state_ff   <= S_IDLE;
                        end else begin
                            state_ff <= S_OPND;
                        end
                    end else begin
                        not_mine_ff <= 1'b1;
                        state_ff    <= S_IDLE;
                    end
                end
                // Extension words, high word first
                S_EXT: begin
                    if (fetch_ack) begin
                        ext_ff      <= {ext_ff[15:0], fetch_data};
                        fa_ff       <= fa_ff + `SBBE_PC_STEP;
                        ext_left_ff <= ext_left_ff - 2'h1;
                        if (kind_ff == K_BT) begin
                            bitn_ff <= fetch_data[7:0];
                        end
                        if (ext_left_ff == 2'h1) begin
                            state_ff <= (kind_ff == K_CALL) ? S_PUSH : S_OPND;
                        end
                    end
                end
                // Operand ready: test bit or check bounds
                S_OPND: begin
                    if (opnd_ok) begin
                        state_ff   <= S_IDLE;
                        done_ff    <= 1'b1;
                        ccr_we_ff  <= 1'b1;
                        ccr_out_ff <= ccr_in;
                        if (kind_ff == K_BT) begin
                            ccr_out_ff[`SBBE_CC_Z] <= ~bit_val;
                        end else if (chk_neg) begin
                            ccr_out_ff[`SBBE_CC_N] <= 1'b1;
                            trap_ff <= 1'b1;
                        end else if (chk_over) begin
                            ccr_out_ff[`SBBE_CC_N] <= 1'b0;
                            trap_ff <= 1'b1;
                        end
                    end
                end
                // Store return address below the stack pointer
                S_PUSH: begin
                    if (push_ack) begin
                        sp_out_ff  <= sp_in - `SBBE_SP_STEP;
                        sp_we_ff   <= 1'b1;
                        new_pc_ff  <= base_ff + disp;
                        pc_load_ff <= 1'b1;
                        done_ff    <= 1'b1;
                        state_ff   <= S_IDLE;
                    end
                end
                default: begin
                    state_ff <= S_IDLE;
                end
            endcase
            // Stack slot and return address, held for the store
            if (state_ff != S_PUSH) begin
                push_addr_ff <= sp_in - `SBBE_SP_STEP;
                // A word taken now moves the return address past it
                if ((state_ff == S_EXT) && fetch_ack) begin
                    push_data_ff <= fa_ff + `SBBE_PC_STEP;
                end else begin
                    push_data_ff <= fa_ff;
                end
            end
        end
    end

endmodule // sbbe_exec

`default_nettype wire

// *** test/sbbe_exec_props.sv ***
/*
 * Port checker for sbbe_exec.
 * Assumes it is bound to every sbbe_exec instance.
 */
`timescale 1ns/1ns
`default_nettype none
module sbbe_exec_chk (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Instruction start
    input wire logic        start,
    input wire logic [31:0] start_pc,
    input wire logic        busy,
    // Completion
    input wire logic        done,
    input wire logic        trap,
    input wire logic [7:0]  trap_vector,
    input wire logic        illegal,
    // Fetch
    input wire logic        fetch_req,
    input wire logic [31:0] fetch_addr,
    input wire logic        fetch_ack,
    // Stack and flow
    input wire logic [31:0] sp_in,
    input wire logic        push_req,
    input wire logic [31:0] push_addr,
    input wire logic        push_ack,
    input wire logic        sp_we,
    input wire logic [31:0] sp_out,
    input wire logic        pc_load,
    // Flags
    input wire logic [4:0]  ccr_in,
    input wire logic        ccr_we,
    input wire logic [4:0]  ccr_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ==========================================================
    // Exceptions, completion and opcode fetch
    a_trap_vector_six:
        assert property (trap |-> done && trap_vector == 8'h06) else $error("bad trap");
    a_illegal_no_effect:
        assert property (illegal |-> !done && !ccr_we && !pc_load && !sp_we)
        else $error("illegal had side effects");

    a_first_fetch_addr:
        assert property (start && !busy |=> fetch_req && fetch_addr == $past(start_pc))
        else $error("opcode fetch address");

    // ==========================================================
    // Call stack push
    a_push_below_sp:
        assert property (push_req |-> push_addr == sp_in - 32'h4) else $error("push address");
    a_call_finishes:
        assert property (push_req && push_ack |=> sp_we && pc_load && done)
        else $error("call did not finish");
    a_stack_step_four:
        assert property (sp_we |-> sp_out == sp_in - 32'h4) else $error("stack step");
    a_call_flags_kept:
        assert property (pc_load |-> !ccr_we) else $error("call wrote flags");

    // ==========================================================
    // Flags and fetches
    a_flags_xvc_kept:
        assert property (ccr_we |-> ccr_out[4] == ccr_in[4] && ccr_out[1:0] == ccr_in[1:0])
        else $error("kept flags changed");
    a_fetch_ascends:
        assert property (fetch_req && fetch_ack ##1 fetch_req |->
            fetch_addr == $past(fetch_addr) + 32'h2) else $error("fetch order");
    a_fetch_req_holds:
        assert property (fetch_req && !fetch_ack |=> fetch_req && $stable(fetch_addr))
        else $error("fetch dropped");
endmodule // sbbe_exec_chk
bind sbbe_exec sbbe_exec_chk sbbe_exec_chk_inst (
    .clk(clk), .rst(rst), .start(start), .start_pc(start_pc), .busy(busy),
    .done(done), .trap(trap), .trap_vector(trap_vector), .illegal(illegal),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_ack(fetch_ack),
    .sp_in(sp_in), .push_req(push_req), .push_addr(push_addr), .push_ack(push_ack),
    .sp_we(sp_we), .sp_out(sp_out), .pc_load(pc_load), .ccr_in(ccr_in),
    .ccr_we(ccr_we), .ccr_out(ccr_out)
);
`default_nettype wire

// *** test/sbbe_progmem.sv ***
/*
 * Far-side model: program memory, operand unit and stack store.
 * Assumes the opcode sits at start_pc with its extension words after it.
 */
`timescale 1ns/1ns
`default_nettype none
module sbbe_progmem (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Instruction image and pacing
    input  wire logic [31:0] start_pc,
    input  wire logic [15:0] w0,
    input  wire logic [15:0] w1,
    input  wire logic [15:0] w2,
    input  wire logic [31:0] opv,
    input  wire logic [1:0]  lag,
    // Word fetch port
    input  wire logic        fetch_req,
    input  wire logic [31:0] fetch_addr,
    output logic             fetch_ack,
    output logic [15:0]      fetch_data,
    // Operand and stack ports
    input  wire logic        opnd_req,
    output logic             opnd_ack,
    output logic [31:0]      opnd_data,
    input  wire logic        push_req,
    output logic             push_ack
);
    logic [1:0] wait_ff;
    logic [1:0] idx;

    // Word index of the fetch relative to the opcode
    assign idx = fetch_addr[2:1] - start_pc[2:1];

    // ==========================================================
    // Answer after lag idle cycles; undriven data toggles
    always @(posedge clk) begin
        fetch_ack <= 1'b0;
        opnd_ack <= 1'b0;
        push_ack <= 1'b0;
        fetch_data <= ~fetch_data;
        opnd_data <= ~opnd_data;
        if (rst) begin
            wait_ff <= 2'h0;
            fetch_data <= 16'h0000;
            opnd_data <= 32'h00000000;
        end else if (wait_ff != lag && (fetch_req || opnd_req || push_req)) begin
            wait_ff <= wait_ff + 2'h1;
        end else begin
            wait_ff <= 2'h0;
            if (fetch_req && !fetch_ack) begin
                fetch_ack <= 1'b1;
                fetch_data <= (idx == 2'h0) ? w0 : (idx == 2'h1) ? w1 : w2;
            end
            if (opnd_req && !opnd_ack) begin
                opnd_ack <= 1'b1;
                opnd_data <= opv;
            end
            if (push_req && !push_ack) begin
                push_ack <= 1'b1;
            end
        end
    end
endmodule // sbbe_progmem
`default_nettype wire

// *** test/tb_sbbe_exec.sv ***
/*
 * Self-checking bench for sbbe_exec: corner and random instructions.
 * Assumes sbbe_progmem answers the fetch, operand and stack ports.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_sbbe_exec;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        start = 1'b0;
    logic [31:0] start_pc = 32'h0, sp_in = 32'h0, opv = 32'h0, ret_cap;
    logic [15:0] w0 = 16'h0, w1 = 16'h0, w2 = 16'h0;
    logic [4:0]  ccr_in = 5'h0;
    logic [1:0]  lag = 2'h0;
    logic [7:0]  opnd_cap;
    logic [31:0] dregs [0:7];
    logic [15:0] c_op [0:14] = '{16'h6100, 16'h61FF, 16'h6180, 16'h617F, 16'h0800,
        16'h0800, 16'h0810, 16'h0F00, 16'h013C, 16'h083C, 16'h0108, 16'h0808,
        16'h4180, 16'h4188, 16'h4090};
    logic [15:0] c_ext [0:14] = '{16'hFFFE, 16'h8000, 16'h0, 16'h0, 16'h001F, 16'h0020,
        16'h0009, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    int          seed = 71, bad_count = 0, n_compared = 0;
    wire         busy, fetch_req, fetch_ack, opnd_req, opnd_ack, push_req, push_ack;
    wire         sp_we, pc_load, ccr_we, done, trap, illegal, not_mine;
    wire [31:0]  fetch_addr, dreg_data, opnd_data, push_addr, push_data, sp_out, new_pc;
    wire [15:0]  fetch_data;
    wire [2:0]   dreg_sel, opnd_mode, opnd_reg;
    wire [1:0]   opnd_size;
    wire [4:0]   ccr_out;
    wire [7:0]   trap_vector;

    sbbe_exec sbbe_exec_inst (
        .clk(clk), .rst(rst), .start(start), .start_pc(start_pc), .busy(busy),
        .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_ack(fetch_ack),
        .fetch_data(fetch_data), .dreg_sel(dreg_sel), .dreg_data(dreg_data),
        .opnd_req(opnd_req), .opnd_mode(opnd_mode), .opnd_reg(opnd_reg),
        .opnd_size(opnd_size), .opnd_ack(opnd_ack), .opnd_data(opnd_data),
        .sp_in(sp_in), .push_req(push_req), .push_addr(push_addr),
        .push_data(push_data), .push_ack(push_ack), .sp_we(sp_we), .sp_out(sp_out),
        .pc_load(pc_load), .new_pc(new_pc), .ccr_in(ccr_in), .ccr_we(ccr_we),
        .ccr_out(ccr_out), .done(done), .trap(trap), .trap_vector(trap_vector),
        .illegal(illegal), .not_mine(not_mine)
    );
    sbbe_progmem sbbe_progmem_inst (
        .clk(clk), .rst(rst), .start_pc(start_pc), .w0(w0), .w1(w1), .w2(w2),
        .opv(opv), .lag(lag), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
        .fetch_ack(fetch_ack), .fetch_data(fetch_data), .opnd_req(opnd_req),
        .opnd_ack(opnd_ack), .opnd_data(opnd_data), .push_req(push_req),
        .push_ack(push_ack)
    );

    // Clock and same-cycle register file
    always #5 clk = ~clk;
    assign dreg_data = dregs[dreg_sel];

    // Capture the stack store and the operand request
    always @(posedge clk) begin
        if (push_req && push_ack) ret_cap <= push_data;
        if (start) opnd_cap <= 8'h03;
        else if (opnd_req && opnd_ack) opnd_cap <= {opnd_mode, opnd_reg, opnd_size};
    end

    // ==========================================================
    // Helpers
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic ea_ok(input logic [5:0] ea, input logic imm);
        return ea[5:3] == 3'h0 || (ea[5:3] >= 3'h2 && ea[5:3] <= 3'h6)
            || (ea[5:3] == 3'h7 && (ea[2:0] <= 3'h3 || (imm && ea[2:0] == 3'h4)));
    endfunction

    // Kind: 0 call, 1 bit test, 2 check, 3 illegal, 4 foreign
    function automatic int kind_of(input logic [15:0] op);
        if (op[15:8] == 8'h61) return 0;
        if (op[15:6] == 10'h020) return ea_ok(op[5:0], 1'b0) ? 1 : 3;
        if (op[15:12] == 4'h0 && op[8:6] == 3'h4) return ea_ok(op[5:0], 1'b1) ? 1 : 3;
        if (op[15:12] == 4'h4 && op[8] && !op[6]) return ea_ok(op[5:0], 1'b0) ? 2 : 3;
        return 4;
    endfunction

    // ==========================================================
    // One instruction: drive, predict, wait, compare
    task automatic run_op(input logic [15:0] op, input logic [15:0] ext);
        int          k, i;
        logic [31:0] r, dst, bnd, tgt, ret;
        logic [4:0]  ccr_x;
        logic [5:0]  flg;
        logic [1:0]  sz_x;
        logic [7:0]  cap_x;
        logic        t;
        r = $random(seed);
        for (i = 0; i < 8; i++) dregs[i] = $random(seed) >>> ($random(seed) & 31);
        opv = $random(seed) >>> ($random(seed) & 31);
        start_pc = $random(seed) & 32'hFFFFFFFE;
        sp_in = $random(seed) & 32'hFFFFFFFC;
        {w2, ccr_in, lag} = {r[31:16], r[4:0], r[6:5]};
        {w0, w1, start} = {op, ext, 1'b1};
        k = kind_of(op);
        {tgt, ret, ccr_x, sz_x, t} = {start_pc + 32'h2, start_pc + 32'h2, ccr_in, 2'h3, 1'b0};
        if (k == 0 && op[7:0] == 8'h00) begin
            tgt = tgt + {{16{ext[15]}}, ext};
            ret = ret + 32'h2;
        end else if (k == 0 && op[7:0] == 8'hFF) begin
            tgt = tgt + {ext, w2};
            ret = ret + 32'h4;
        end else if (k == 0) tgt = tgt + {{24{op[7]}}, op[7:0]};
        if (k == 1) begin
            dst = op[8] ? dregs[op[11:9]] : {24'h0, ext[7:0]};
            ccr_x[2] = (op[5:3] == 3'h0) ? ~dregs[op[2:0]][dst[4:0]] : ~opv[dst[2:0]];
            sz_x = (op[5:3] == 3'h0) ? 2'h3 : 2'h0;
        end
        if (k == 2) begin
            dst = dregs[op[11:9]];
            bnd = (op[5:3] == 3'h0) ? dregs[op[2:0]] : opv;
            if (op[7]) {dst, bnd} = {{16{dst[15]}}, dst[15:0], {16{bnd[15]}}, bnd[15:0]};
            t = dst[31] || ($signed(dst) > $signed(bnd));
            if (t) ccr_x[3] = dst[31];
            sz_x = (op[5:3] == 3'h0) ? 2'h3 : op[7] ? 2'h1 : 2'h2;
        end
        case (k)
            0: flg = 6'h21;
            1: flg = 6'h22;
            2: flg = {1'b1, t, 4'h2};
            3: flg = 6'h08;
            default: flg = 6'h04;
        endcase
        @(negedge clk);
        start = 1'b0;
        for (i = 0; i < 200 && (done | illegal | not_mine) !== 1'b1; i++) @(negedge clk);
        if (i == 200) begin
            cmp({31'h0, done | illegal | not_mine}, 32'h1);
            final_report();
        end else begin
            cap_x = (sz_x == 2'h3) ? 8'h03 : {op[5:0], sz_x};
            cmp({done, trap, illegal, not_mine, ccr_we, pc_load}, {26'h0, flg});
            cmp({31'h0, busy}, 32'h0);
            cmp({24'h0, opnd_cap}, {24'h0, cap_x});
            if (k == 0) begin
                cmp(new_pc, tgt);
                cmp(ret_cap, ret);
                cmp(sp_out, sp_in - 32'h4);
            end
            if (k == 1 || k == 2) cmp({27'h0, ccr_out}, {27'h0, ccr_x});
            if (t) cmp({24'h0, trap_vector}, 32'h6);
            @(negedge clk);
        end
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] rr;
        for (int j = 0; j < 8; j++) dregs[j] = 32'h0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        // Boundary displacements, bit numbers and refused modes
        for (int j = 0; j < 15; j++) run_op(c_op[j], c_ext[j]);
        // Fixed-seed mix over the four opcode shapes
        repeat (300) begin
            rr = $random(seed);
            case (rr[17:16])
                2'h0: run_op({8'h61, rr[7:0]}, rr[31:16]);
                2'h1: run_op({10'h020, rr[5:0]}, {8'h00, rr[31:24]});
                2'h2: run_op({4'h0, rr[11:9], 3'h4, rr[5:0]}, rr[31:16]);
                default: run_op({4'h4, rr[11:9], rr[8:7], 1'b0, rr[5:0]}, rr[31:16]);
            endcase
        end
        final_report();
    end
endmodule // tb_sbbe_exec
`default_nettype wire
